// ==== pwr_link_if.sv ====
// link between host processor and the reset/power-mode block
// assumes both ends run on the same reference clock
`timescale 1ns/1ps
interface pwr_link_if;
  logic hw_reset_n;
  logic req;
  logic we;
  logic [15:0] addr;
  logic [15:0] wdata;
  logic ack;
  logic err;
  logic [15:0] rdata;
  logic busy;

  modport device (
    input hw_reset_n, req, we, addr, wdata,
    output ack, err, rdata, busy
  );

  modport host (
    output hw_reset_n, req, we, addr, wdata,
    input ack, err, rdata, busy
  );
endinterface

// ==== pwr_reset_asserts.sv ====
// assertions on the host-device link and the device mode outputs
// assumes one clock; instantiated beside the link interface
`timescale 1ns/1ps
`include "pwr_reset_defines.svh"
module pwr_reset_asserts
  import pwr_reset_pkg::*;
#(
  parameter int NUM_MODULES = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // link
  input wire logic hw_reset_n,
  input wire logic req,
  input wire logic we,
  input wire logic [15:0] addr,
  input wire logic ack,
  input wire logic err,
  input wire logic busy,
  // device status
  input wire mode_t mode,
  input wire logic pll_en,
  input wire logic [NUM_MODULES-1:0] clk_en,
  input wire logic [NUM_MODULES-1:0] module_active
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_take_ack;
    req && !ack && !busy && hw_reset_n |=> ack;
  endproperty
  a_take_ack: assert property (p_take_ack)
    else $error("request not answered in the next cycle");

  property p_srst_busy;
    ack && we && !err && addr == `ADDR_SOFT_RESET |-> busy [*4] ##1 !busy;
  endproperty
  a_srst_busy: assert property (p_srst_busy)
    else $error("software reset gap not four cycles");

  property p_busy_no_ack;
    busy |=> !ack;
  endproperty
  a_busy_no_ack: assert property (p_busy_no_ack)
    else $error("access answered during reset gap");

  property p_standby_pll;
    (mode == MODE_STANDBY) [*2] |-> !pll_en;
  endproperty
  a_standby_pll: assert property (p_standby_pll)
    else $error("pll left on in standby");

  property p_lowpower_clk;
    (mode != MODE_NORMAL) [*2] |-> clk_en == '0;
  endproperty
  a_lowpower_clk: assert property (p_lowpower_clk)
    else $error("clock running in a low power mode");

  // one cycle of settling for the registered gate
  property p_normal_gate;
    (mode == MODE_NORMAL && hw_reset_n) [*2] ##0 $stable(module_active)
      |-> clk_en == module_active;
  endproperty
  a_normal_gate: assert property (p_normal_gate)
    else $error("normal mode clock gate wrong");

  property p_mode_by_write;
    // mode register and ack update on the same edge
    $changed(mode) |-> (ack && we) || $past(!hw_reset_n);
  endproperty
  a_mode_by_write: assert property (p_mode_by_write)
    else $error("mode changed without a write");

  property p_async_ok;
    ack && mode != MODE_NORMAL && addr <= `ADDR_LO_END && !addr[0]
      |-> !err;
  endproperty
  a_async_ok: assert property (p_async_ok)
    else $error("asynchronous register refused in low power");

  property p_hw_defaults;
    !hw_reset_n |=> pll_en && mode == MODE_NORMAL && !busy;
  endproperty
  a_hw_defaults: assert property (p_hw_defaults)
    else $error("hardware reset left state behind");

  c_srst: cover property (ack && we && addr == `ADDR_SOFT_RESET);
  c_standby: cover property (mode == MODE_STANDBY);
  c_ps: cover property (mode == MODE_POWER_SAVE);
  c_refused: cover property (ack && err);
endmodule

// ==== pwr_reset_defines.svh ====
// register map, field positions, reset values and timing counts
// assumes 16-bit word registers on even byte addresses
`ifndef PWR_RESET_DEFINES_SVH
`define PWR_RESET_DEFINES_SVH

`define REG_DEFAULT 16'h0000
// asynchronous range one
`define ADDR_LO_BASE 16'h0000
`define ADDR_LO_END 16'h0018
`define LO_WORDS 13
// clock configuration span
`define ADDR_CLKCFG_BASE 16'h000E
`define ADDR_PLL_END 16'h0012
`define ADDR_PWR_CTRL 16'h0014
`define ADDR_SOFT_RESET 16'h0016
`define ADDR_SYS_CLOCK 16'h0018
`define IDX_PWR_CTRL 4'hA
`define IDX_SYS_CLOCK 4'hC
// asynchronous range two
`define ADDR_HI_BASE 16'h0300
`define ADDR_HI_END 16'h031A
`define HI_WORDS 14
`define IDX_BYPASS_CTRL 4'h0
// ordinary registers, cleared by software reset
`define ADDR_SYNC_BASE 16'h0400
// fields of the power control and bypass control words
`define BIT_POWER_SAVE 0
`define BIT_STANDBY 1
`define BIT_MEM_IDLE 6
`define BIT_BYPASS_EN 0
// timing
`define HW_RESET_CYCLES 3'h2
`define SRST_CYCLES 3'h4
`define CLK_FREQ_KHZ 40000
`define PLL_SETTLE_MS 1
`define PLL_SETTLE_CYCLES (`PLL_SETTLE_MS * `CLK_FREQ_KHZ)

`endif

// ==== pwr_reset_device.sv ====
// device end: register file, reset handling and power-mode control
// assumes the host shares clk and keeps its own link obligations
// Operation
// - host pulses reset low two clock cycles
// - hardware reset restores every register default
// - clock registers usable right after reset
// - writing 0016h starts a software reset
// - software reset spares both asynchronous ranges
// - no access four cycles after software reset
// - standby stops all clocks, PLL off
// - host enters standby before PLL changes
// - standby keeps async registers and bypass alive
// - power save stops all internal clocks
// - power save before writing 0018h
// - hold power save while PLL settles; a write from standby straight to normal is not held
// - power save keeps async registers, bypass
// - normal mode gates clocks of idle modules
// - check memory idle before power save; the host skips the check when entering power save from standby
`timescale 1ns/1ps
`include "pwr_reset_defines.svh"

module pwr_reset_device
  import pwr_reset_pkg::*;
#(
  parameter int NUM_MODULES = 4,
  parameter int SYNC_WORDS = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // link to host
  pwr_link_if.device link,
  // core status
  input wire logic mem_idle,
  input wire logic [NUM_MODULES-1:0] module_active,
  // clock and mode control
  output logic [NUM_MODULES-1:0] clk_en,
  output logic pll_en,
  output mode_t mode,
  output logic lcd_bypass_en,
  output logic [15:0] sys_clk_setting
);

  localparam int SW_AW = (SYNC_WORDS > 1) ? $clog2(SYNC_WORDS) : 1;
  localparam logic [15:0] SYNC_END =
    16'(`ADDR_SYNC_BASE + 2 * SYNC_WORDS);

  logic [15:0] lo_q [`LO_WORDS];
  logic [15:0] lo_d [`LO_WORDS];
  logic [15:0] hi_q [`HI_WORDS];
  logic [15:0] hi_d [`HI_WORDS];
  logic [15:0] sy_q [SYNC_WORDS];
  logic [15:0] sy_d [SYNC_WORDS];
  logic ack_q, ack_d;
  logic err_q, err_d;
  logic [15:0] rdata_q, rdata_d;
  logic [2:0] srst_q, srst_d;
  mode_t mode_q, mode_d;
  logic pll_en_q, pll_en_d;
  logic [NUM_MODULES-1:0] clk_en_q, clk_en_d;
  logic bypass_q, bypass_d;
  logic [15:0] sysclk_q, sysclk_d;

  assign link.ack = ack_q;
  assign link.err = err_q;
  assign link.rdata = rdata_q;
  assign link.busy = (srst_q != 3'h0);
  assign clk_en = clk_en_q;
  assign pll_en = pll_en_q;
  assign mode = mode_q;
  assign lcd_bypass_en = bypass_q;
  assign sys_clk_setting = sysclk_q;

  // register access and reset handling
  always_comb begin
    logic take;
    logic in_lo;
    logic in_hi;
    logic in_sy;
    logic [15:0] off_hi;
    logic [15:0] off_sy;
    logic [3:0] idx_lo;
    logic [3:0] idx_hi;
    logic [SW_AW-1:0] idx_sy;
    logic ps_now;
    take = 1'b0;
    in_lo = 1'b0;
    in_hi = 1'b0;
    in_sy = 1'b0;
    off_hi = link.addr - `ADDR_HI_BASE;
    off_sy = link.addr - `ADDR_SYNC_BASE;
    idx_lo = link.addr[4:1];
    idx_hi = off_hi[4:1];
    idx_sy = off_sy[SW_AW:1];
    ps_now = (mode_q != MODE_NORMAL);
    lo_d = lo_q;
    hi_d = hi_q;
    sy_d = sy_q;
    ack_d = 1'b0;
    err_d = 1'b0;
    rdata_d = rdata_q;
    srst_d = (srst_q != 3'h0) ? srst_q - 3'h1 : 3'h0;
    // one request at a time; a held req is not taken again in its ack cycle
    take = link.req && !ack_q && (srst_q == 3'h0);
    if (!link.addr[0]) begin
      in_lo = (link.addr <= `ADDR_LO_END);
      in_hi = (link.addr >= `ADDR_HI_BASE) &&
              (link.addr <= `ADDR_HI_END);
      in_sy = (link.addr >= `ADDR_SYNC_BASE) && (link.addr < SYNC_END);
    end
    if (take) begin
      ack_d = 1'b1;
      rdata_d = `REG_DEFAULT;
      if (in_lo) begin
        // async range answers in every mode
        if (link.we) begin
          lo_d[idx_lo] = link.wdata;
          if (link.addr == `ADDR_PWR_CTRL) begin
            lo_d[idx_lo][`BIT_MEM_IDLE] = 1'b0;
          end
          if (link.addr == `ADDR_SOFT_RESET) begin
            srst_d = `SRST_CYCLES;
            for (int i = 0; i < SYNC_WORDS; i++) begin
              sy_d[i] = `REG_DEFAULT;
            end
          end
        end else begin
          rdata_d = lo_q[idx_lo];
          if (link.addr == `ADDR_PWR_CTRL) begin
            rdata_d[`BIT_MEM_IDLE] = mem_idle;
          end
        end
      end else if (in_hi) begin
        if (link.we) begin
          hi_d[idx_hi] = link.wdata;
        end else begin
          rdata_d = hi_q[idx_hi];
        end
      end else if (in_sy && !ps_now) begin
        if (link.we) begin
          sy_d[idx_sy] = link.wdata;
        end else begin
          rdata_d = sy_q[idx_sy];
        end
      end else begin
        // clocked registers are dark outside normal mode
        err_d = 1'b1;
      end
    end
    if (!link.hw_reset_n) begin
      for (int i = 0; i < `LO_WORDS; i++) begin
        lo_d[i] = `REG_DEFAULT;
      end
      for (int i = 0; i < `HI_WORDS; i++) begin
        hi_d[i] = `REG_DEFAULT;
      end
      for (int i = 0; i < SYNC_WORDS; i++) begin
        sy_d[i] = `REG_DEFAULT;
      end
      ack_d = 1'b0;
      err_d = 1'b0;
      rdata_d = `REG_DEFAULT;
      srst_d = 3'h0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < `LO_WORDS; i++) begin
        lo_q[i] <= `REG_DEFAULT;
      end
      for (int i = 0; i < `HI_WORDS; i++) begin
        hi_q[i] <= `REG_DEFAULT;
      end
      for (int i = 0; i < SYNC_WORDS; i++) begin
        sy_q[i] <= `REG_DEFAULT;
      end
      ack_q <= 1'b0;
      err_q <= 1'b0;
      rdata_q <= `REG_DEFAULT;
      srst_q <= 3'h0;
    end else begin
      lo_q <= lo_d;
      hi_q <= hi_d;
      sy_q <= sy_d;
      ack_q <= ack_d;
      err_q <= err_d;
      rdata_q <= rdata_d;
      srst_q <= srst_d;
    end
  end

  // mode follows the stored control word only; standby wins
  always_comb begin
    logic [15:0] ctl;
    ctl = lo_d[`IDX_PWR_CTRL];
    if (ctl[`BIT_STANDBY]) begin
      mode_d = MODE_STANDBY;
    end else if (ctl[`BIT_POWER_SAVE]) begin
      mode_d = MODE_POWER_SAVE;
    end else begin
      mode_d = MODE_NORMAL;
    end
    pll_en_d = (mode_d != MODE_STANDBY);
    // idle modules lose their clock even in normal mode
    clk_en_d = (mode_d == MODE_NORMAL) ? module_active : '0;
    // bypass is independent of mode
    bypass_d = hi_d[`IDX_BYPASS_CTRL][`BIT_BYPASS_EN];
    sysclk_d = lo_d[`IDX_SYS_CLOCK];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= MODE_NORMAL;
      pll_en_q <= 1'b1;
      clk_en_q <= '0;
      bypass_q <= 1'b0;
      sysclk_q <= `REG_DEFAULT;
    end else begin
      mode_q <= mode_d;
      pll_en_q <= pll_en_d;
      clk_en_q <= clk_en_d;
      bypass_q <= bypass_d;
      sysclk_q <= sysclk_d;
    end
  end

endmodule

// ==== pwr_reset_host.sv ====
// host end: reset pulse, register requests and mode-change ordering
// assumes the device answers each req with a one-cycle ack
`timescale 1ns/1ps
`include "pwr_reset_defines.svh"

module pwr_reset_host
  import pwr_reset_pkg::*;
#(
  parameter int PLL_SETTLE_CYCLES = `PLL_SETTLE_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // link to device
  pwr_link_if.host link,
  // user command port
  input wire logic hw_reset_req,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_write,
  input wire logic [15:0] cmd_addr,
  input wire logic [15:0] cmd_wdata,
  // user response port
  output logic rsp_valid,
  output logic rsp_err,
  output logic [15:0] rsp_rdata,
  output logic link_ready
);

  localparam int TW = $clog2(PLL_SETTLE_CYCLES + 1);

  host_state_t state_q, state_d;
  logic [2:0] cnt_q, cnt_d;
  logic [TW-1:0] settle_q, settle_d;
  logic hwrst_n_q, hwrst_n_d;
  logic we_q, we_d;
  logic [15:0] addr_q, addr_d;
  logic [15:0] wdata_q, wdata_d;
  logic ps_q, ps_d;
  logic sb_q, sb_d;
  logic rsp_valid_q, rsp_valid_d;
  logic rsp_err_q, rsp_err_d;
  logic [15:0] rsp_rdata_q, rsp_rdata_d;

  assign link.hw_reset_n = hwrst_n_q;
  assign link.req = (state_q == HS_POLL) || (state_q == HS_ISSUE);
  assign link.we = (state_q == HS_ISSUE) && we_q;
  assign link.addr = (state_q == HS_POLL) ? `ADDR_PWR_CTRL : addr_q;
  assign link.wdata = wdata_q;
  assign cmd_ready = (state_q == HS_IDLE) && !hw_reset_req;
  assign rsp_valid = rsp_valid_q;
  assign rsp_err = rsp_err_q;
  assign rsp_rdata = rsp_rdata_q;
  assign link_ready = (state_q != HS_RESET);

  always_comb begin
    logic pll_reg;
    logic ps_set;
    pll_reg = (cmd_addr >= `ADDR_CLKCFG_BASE) && (cmd_addr <= `ADDR_PLL_END);
    ps_set = cmd_wdata[`BIT_POWER_SAVE] && !ps_q && !sb_q;
    state_d = state_q;
    cnt_d = cnt_q;
    settle_d = (settle_q != '0) ? settle_q - TW'(1) : settle_q;
    hwrst_n_d = hwrst_n_q;
    we_d = we_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    ps_d = ps_q;
    sb_d = sb_q;
    rsp_valid_d = 1'b0;
    rsp_err_d = 1'b0;
    rsp_rdata_d = rsp_rdata_q;
    unique case (state_q)
      HS_RESET: begin
        cnt_d = cnt_q + 3'h1;
        if (cnt_q == `HW_RESET_CYCLES - 3'h1) begin
          hwrst_n_d = 1'b1;
          state_d = HS_IDLE;
        end
      end
      HS_IDLE: begin
        if (hw_reset_req) begin
          hwrst_n_d = 1'b0;
          cnt_d = 3'h0;
          ps_d = 1'b0;
          sb_d = 1'b0;
          state_d = HS_RESET;
        end else if (cmd_valid) begin
          we_d = cmd_write;
          addr_d = cmd_addr;
          wdata_d = cmd_wdata;
          state_d = HS_ISSUE;
          if (cmd_write && pll_reg && !sb_q) begin
            state_d = HS_IDLE;
          end else if (cmd_write && cmd_addr == `ADDR_SYS_CLOCK &&
                       !ps_q && !sb_q) begin
            state_d = HS_IDLE;
          end else if (cmd_write && cmd_addr == `ADDR_PWR_CTRL) begin
            if (!cmd_wdata[`BIT_POWER_SAVE] &&
                !cmd_wdata[`BIT_STANDBY] && settle_q != '0) begin
              state_d = HS_IDLE;
            end else if (ps_set) begin
              state_d = HS_POLL;
            end
          end
          if (state_d == HS_IDLE) begin
            rsp_valid_d = 1'b1;
            rsp_err_d = 1'b1;
            rsp_rdata_d = `REG_DEFAULT;
          end
        end
      end
      HS_POLL: begin
        // keep polling until the memory controller reports idle
        if (link.ack && link.rdata[`BIT_MEM_IDLE]) begin
          state_d = HS_ISSUE;
        end
      end
      HS_ISSUE: begin
        if (link.ack) begin
          rsp_valid_d = 1'b1;
          rsp_err_d = link.err;
          rsp_rdata_d = link.rdata;
          state_d = HS_IDLE;
          if (we_q && addr_q == `ADDR_PWR_CTRL && !link.err) begin
            ps_d = wdata_q[`BIT_POWER_SAVE];
            sb_d = wdata_q[`BIT_STANDBY];
            if (sb_q && !wdata_q[`BIT_STANDBY]) begin
              settle_d = TW'(PLL_SETTLE_CYCLES);
            end
          end
          if (we_q && addr_q == `ADDR_SOFT_RESET) begin
            cnt_d = `SRST_CYCLES;
            state_d = HS_GAP;
          end
        end
      end
      HS_GAP: begin
        cnt_d = cnt_q - 3'h1;
        if (cnt_q == 3'h1) begin
          state_d = HS_IDLE;
        end
      end
      default: begin
        state_d = HS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= HS_RESET;
      cnt_q <= 3'h0;
      settle_q <= '0;
      hwrst_n_q <= 1'b0;
      we_q <= 1'b0;
      addr_q <= `REG_DEFAULT;
      wdata_q <= `REG_DEFAULT;
      ps_q <= 1'b0;
      sb_q <= 1'b0;
      rsp_valid_q <= 1'b0;
      rsp_err_q <= 1'b0;
      rsp_rdata_q <= `REG_DEFAULT;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      settle_q <= settle_d;
      hwrst_n_q <= hwrst_n_d;
      we_q <= we_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      ps_q <= ps_d;
      sb_q <= sb_d;
      rsp_valid_q <= rsp_valid_d;
      rsp_err_q <= rsp_err_d;
      rsp_rdata_q <= rsp_rdata_d;
    end
  end

endmodule

// ==== pwr_reset_pkg.sv ====
// types shared by both ends of the reset and power-mode link
// assumes nothing beyond the defines header
package pwr_reset_pkg;

  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_POWER_SAVE = 2'b01,
    MODE_STANDBY = 2'b10
  } mode_t;

  typedef enum logic [2:0] {
    HS_RESET = 3'b000,
    HS_IDLE = 3'b001,
    HS_POLL = 3'b010,
    HS_ISSUE = 3'b011,
    HS_GAP = 3'b100
  } host_state_t;

endpackage

// ==== reset_and_power_mode_control_bench.sv ====
// self-checking bench: host and device joined over the link interface
// assumes a 40 MHz clock and a shortened pll settle count
`timescale 1ns/1ps
module reset_and_power_mode_control_bench
  import pwr_reset_pkg::*;
;
  localparam int SETTLE = 20;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic mem_idle = 1'b1;
  logic [3:0] module_active = 4'h0;
  logic [3:0] clk_en;
  logic pll_en;
  mode_t mode;
  logic lcd_bypass_en;
  logic [15:0] sys_clk_setting;
  logic hw_reset_req = 1'b0;
  logic cmd_valid = 1'b0;
  logic cmd_ready;
  logic cmd_write = 1'b0;
  logic [15:0] cmd_addr = 16'h0000;
  logic [15:0] cmd_wdata = 16'h0000;
  logic rsp_valid;
  logic rsp_err;
  logic [15:0] rsp_rdata;
  logic link_ready;
  int fail_count = 0;
  int n_checks = 0;
  logic e;
  logic [15:0] r;

  pwr_link_if u_pwr_link_if ();
  pwr_reset_device #(.NUM_MODULES(4), .SYNC_WORDS(8)) u_pwr_reset_device (
    .clk(clk), .rst_n(rst_n), .link(u_pwr_link_if), .mem_idle(mem_idle),
    .module_active(module_active), .clk_en(clk_en), .pll_en(pll_en),
    .mode(mode), .lcd_bypass_en(lcd_bypass_en),
    .sys_clk_setting(sys_clk_setting));
  pwr_reset_host #(.PLL_SETTLE_CYCLES(SETTLE)) u_pwr_reset_host (
    .clk(clk), .rst_n(rst_n), .link(u_pwr_link_if),
    .hw_reset_req(hw_reset_req), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_write(cmd_write), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_err(rsp_err),
    .rsp_rdata(rsp_rdata), .link_ready(link_ready));
  pwr_reset_asserts #(.NUM_MODULES(4)) u_pwr_reset_asserts (
    .clk(clk), .rst_n(rst_n), .hw_reset_n(u_pwr_link_if.hw_reset_n),
    .req(u_pwr_link_if.req), .we(u_pwr_link_if.we),
    .addr(u_pwr_link_if.addr), .ack(u_pwr_link_if.ack),
    .err(u_pwr_link_if.err), .busy(u_pwr_link_if.busy), .mode(mode),
    .pll_en(pll_en), .clk_en(clk_en), .module_active(module_active));

  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // cmd_ready is combinational, so it is judged at the falling edge
  task automatic acc(input logic w, input logic [15:0] a, d);
    logic t;
    int n;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_write <= w;
    cmd_addr <= a;
    cmd_wdata <= d;
    t = 1'b0;
    while (t !== 1'b1) begin
      @(negedge clk);
      t = cmd_ready;
      @(posedge clk);
    end
    cmd_valid <= 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    chk("rsp_valid", 16'(rsp_valid), 16'h0001);
    e = rsp_err;
    r = rsp_rdata;
  endtask

  task automatic ex(input logic w, input logic [15:0] a, d,
                    input logic ee, input logic [15:0] er, input string what);
    acc(w, a, d);
    chk({what, " err"}, 16'(e), 16'(ee));
    if (!w) chk(what, r, er);
  endtask

  task automatic t_defaults();
    ex(1'b0, 16'h000E, 16'h0000, 1'b0, 16'h0000, "clkcfg");
    ex(1'b0, 16'h0300, 16'h0000, 1'b0, 16'h0000, "hi reg");
    chk("pll_en", 16'(pll_en), 16'h0001);
    ex(1'b1, 16'h000E, 16'h0033, 1'b1, 16'h0000, "pll wr normal");
    ex(1'b1, 16'h0018, 16'h0055, 1'b1, 16'h0000, "sysclk wr normal");
    ex(1'b0, 16'h0200, 16'h0000, 1'b1, 16'h0000, "unmapped");
    @(posedge clk);
    module_active <= 4'h5;
    repeat (3) @(negedge clk);
    chk("clk_en", 16'(clk_en), 16'h0005);
  endtask

  task automatic t_soft_reset();
    ex(1'b1, 16'h0300, 16'h0001, 1'b0, 16'h0000, "bypass wr");
    ex(1'b1, 16'h0002, 16'h1234, 1'b0, 16'h0000, "lo wr");
    ex(1'b1, 16'h0400, 16'hABCD, 1'b0, 16'h0000, "sync wr");
    ex(1'b0, 16'h0400, 16'h0000, 1'b0, 16'hABCD, "sync rd");
    ex(1'b1, 16'h0016, 16'h0001, 1'b0, 16'h0000, "srst");
    ex(1'b0, 16'h0400, 16'h0000, 1'b0, 16'h0000, "sync cleared");
    ex(1'b0, 16'h0002, 16'h0000, 1'b0, 16'h1234, "lo kept");
    chk("lcd_bypass_en", 16'(lcd_bypass_en), 16'h0001);
  endtask

  task automatic t_power_save();
    @(posedge clk);
    mem_idle <= 1'b0;
    fork
      ex(1'b1, 16'h0014, 16'h0001, 1'b0, 16'h0000, "ps set");
      begin
        repeat (12) @(negedge clk);
        chk("mode mem busy", 16'(mode), 16'(MODE_NORMAL));
        @(posedge clk);
        mem_idle <= 1'b1;
      end
    join
    repeat (2) @(negedge clk);
    chk("mode ps", 16'(mode), 16'(MODE_POWER_SAVE));
    chk("clk_en ps", 16'(clk_en), 16'h0000);
    ex(1'b1, 16'h0018, 16'h0055, 1'b0, 16'h0000, "sysclk wr");
    chk("sys_clk_setting", sys_clk_setting, 16'h0055);
    ex(1'b0, 16'h0400, 16'h0000, 1'b1, 16'h0000, "sync in ps");
    ex(1'b0, 16'h0300, 16'h0000, 1'b0, 16'h0001, "hi in ps");
  endtask

  task automatic t_standby();
    ex(1'b1, 16'h0014, 16'h0002, 1'b0, 16'h0000, "standby");
    repeat (2) @(negedge clk);
    chk("pll_en sb", 16'(pll_en), 16'h0000);
    chk("clk_en sb", 16'(clk_en), 16'h0000);
    ex(1'b1, 16'h000E, 16'h0033, 1'b0, 16'h0000, "pll wr sb");
    ex(1'b0, 16'h000E, 16'h0000, 1'b0, 16'h0033, "pll rd sb");
    ex(1'b1, 16'h0014, 16'h0001, 1'b0, 16'h0000, "sb to ps");
    ex(1'b1, 16'h0014, 16'h0000, 1'b1, 16'h0000, "early normal");
    repeat (SETTLE) @(negedge clk);
    ex(1'b1, 16'h0014, 16'h0000, 1'b0, 16'h0000, "normal");
    repeat (2) @(negedge clk);
    chk("mode normal", 16'(mode), 16'(MODE_NORMAL));
  endtask

  task automatic t_hw_pulse();
    int n;
    int m;
    @(posedge clk);
    hw_reset_req <= 1'b1;
    @(posedge clk);
    hw_reset_req <= 1'b0;
    n = 0;
    m = 0;
    repeat (8) begin
      @(negedge clk);
      if (u_pwr_link_if.hw_reset_n === 1'b0) n++;
      if (link_ready === 1'b0) m++;
    end
    chk("pulse cycles", 16'(n), 16'h0002);
    chk("link_ready low cycles", 16'(m), 16'h0002);
    chk("sys_clk_setting hw", sys_clk_setting, 16'h0000);
    chk("lcd_bypass_en hw", 16'(lcd_bypass_en), 16'h0000);
    ex(1'b0, 16'h000E, 16'h0000, 1'b0, 16'h0000, "clkcfg after hw");
    ex(1'b0, 16'h0300, 16'h0000, 1'b0, 16'h0000, "hi after hw");
  endtask

  initial begin
    forever #12.5 clk = ~clk;
  end

  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_defaults();
    t_soft_reset();
    t_power_save();
    t_standby();
    t_hw_pulse();
    results();
  end

  // whole run needs well under a thousand cycles
  initial begin
    repeat (3000) @(posedge clk);
    fail_count++;
    results();
  end
endmodule
